/* design/wss_pkg.sv */
// Shared constants for the waveform sequence slot bank and its walker
package wss_pkg;

	// Widths
	localparam int ADDR_W = 8; // Register port address width
	localparam int ID_W = 8; // One waveform identifier
	localparam int IDX_W = 3; // Slot index, eight slots in all
	localparam int NUM_LOCAL = 5; // Slots held in this bank
	localparam int NUM_UPPER = 3; // Slots held by the neighbouring bank

	// Register offsets of the local slots
	localparam logic [ADDR_W-1:0] WAVE_SLOT_0_OFF = 8'h03;
	localparam logic [ADDR_W-1:0] WAVE_SLOT_1_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] WAVE_SLOT_2_OFF = 8'h05;
	localparam logic [ADDR_W-1:0] WAVE_SLOT_3_OFF = 8'h06;
	localparam logic [ADDR_W-1:0] WAVE_SLOT_4_OFF = 8'h07;
	localparam logic [ADDR_W-1:0] SLOT_SPAN = 8'h05; // Local slot count

	// Values
	localparam logic [ID_W-1:0] SLOT_RESET = 8'h00; // Slot reset value
	localparam logic [ID_W-1:0] ID_END = 8'h00; // Identifier ending a run
	localparam logic [ID_W-1:0] RDATA_NONE = 8'h00; // Unmapped read value
	localparam logic [IDX_W-1:0] FIRST_SLOT = 3'h0; // Walk starts here
	localparam logic [IDX_W-1:0] LAST_SLOT = 3'h7; // Eighth slot
	localparam logic [IDX_W-1:0] FIRST_UPPER = 3'h5; // First remote slot
	localparam logic [IDX_W-1:0] IDX_STEP = 3'h1; // Walk step

	// Walker states, Gray along idle-fetch-play-done
	typedef enum logic [1:0] {
		WSS_IDLE = 2'h0,
		WSS_FETCH = 2'h1,
		WSS_PLAY = 2'h3,
		WSS_DONE = 2'h2
	} wss_state_t;

	// True when an address falls on one of the local slots
	function automatic logic slot_hit(input logic [ADDR_W-1:0] addr);
		slot_hit = (addr >= WAVE_SLOT_0_OFF) &&
			(addr < (WAVE_SLOT_0_OFF + SLOT_SPAN));
	endfunction : slot_hit

	// Local slot index of an address, valid only on a hit
	function automatic logic [IDX_W-1:0] slot_index(
			input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] diff;
		diff = addr - WAVE_SLOT_0_OFF;
		slot_index = diff[IDX_W-1:0];
	endfunction : slot_index

endpackage : wss_pkg

/* design/wss_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Slot fetch path between the bank and the walker
interface wss_seq_if;
	logic [wss_pkg::IDX_W-1:0] fetch_idx; // Slot the walker looks at
	logic [wss_pkg::ID_W-1:0] fetch_id; // Identifier held in that slot

	// Walker side
	modport engine (
		output fetch_idx,
		input fetch_id
	);

	// Bank side
	modport bank (
		input fetch_idx,
		output fetch_id
	);
endinterface : wss_seq_if
`default_nettype wire

/* design/wss_engine.sv */
`timescale 1ns/1ps
`default_nettype none
// Playback walker: steps through the sequence slots
module wss_engine (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Trigger and synthesizer handshake
	input wire logic go,
	input wire logic play_done,
	output logic play_start,
	output logic [wss_pkg::ID_W-1:0] play_id,
	// Completion and state
	output logic seq_done,
	output logic seq_busy,
	// Slot fetch path
	wss_seq_if.engine sq
);

	wss_pkg::wss_state_t state_q, state_d; // Walker state
	logic [wss_pkg::IDX_W-1:0] idx_q, idx_d; // Current slot
	logic [wss_pkg::ID_W-1:0] id_q, id_d; // Identifier being played
	logic start_q, start_d; // Start pulse to synthesizer
	logic done_q, done_d; // Sequence complete pulse

	//////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		id_d = id_q;
		start_d = 1'b0;
		done_d = 1'b0;
		unique case (state_q)
			// Wait for the trigger bit
			wss_pkg::WSS_IDLE: begin
				if (go) begin
					state_d = wss_pkg::WSS_FETCH;
					idx_d = wss_pkg::FIRST_SLOT;
				end
			end
			// Look at the slot; a cleared trigger cancels
			wss_pkg::WSS_FETCH: begin
				if (!go) begin
					state_d = wss_pkg::WSS_IDLE;
				end else if (sq.fetch_id == wss_pkg::ID_END) begin
					state_d = wss_pkg::WSS_DONE;
					done_d = 1'b1;
				end else begin
					state_d = wss_pkg::WSS_PLAY;
					id_d = sq.fetch_id;
					start_d = 1'b1;
				end
			end
			// Wait for the synthesizer to finish the waveform
			wss_pkg::WSS_PLAY: begin
				if (!go) begin
					state_d = wss_pkg::WSS_IDLE;
				end else if (play_done) begin
					if (idx_q == wss_pkg::LAST_SLOT) begin
						state_d = wss_pkg::WSS_DONE;
						done_d = 1'b1;
					end else begin
						state_d = wss_pkg::WSS_FETCH;
						idx_d = idx_q + wss_pkg::IDX_STEP;
					end
				end
			end
			// Hold until the trigger logic drops the bit; no rerun
			wss_pkg::WSS_DONE: begin
				if (!go) begin
					state_d = wss_pkg::WSS_IDLE;
				end
			end
		endcase
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= wss_pkg::WSS_IDLE;
			idx_q <= wss_pkg::FIRST_SLOT;
			id_q <= wss_pkg::SLOT_RESET;
			start_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			id_q <= id_d;
			start_q <= start_d;
			done_q <= done_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs
	assign sq.fetch_idx = idx_q;
	assign play_start = start_q;
	assign play_id = id_q;
	assign seq_done = done_q;
	assign seq_busy = (state_q == wss_pkg::WSS_FETCH) ||
		(state_q == wss_pkg::WSS_PLAY);

	//////////////////////////////////////////////////////////////////////
	// Checks
	chk_start_first: assert property (@(posedge clk) disable iff (!nrst)
		(state_q == wss_pkg::WSS_IDLE && go) |=>
		(idx_q == wss_pkg::FIRST_SLOT && state_q == wss_pkg::WSS_FETCH))
		else $error("walk did not start at the first slot");

	chk_play_fetched: assert property (@(posedge clk) disable iff (!nrst)
		(state_q == wss_pkg::WSS_FETCH && go &&
		sq.fetch_id != wss_pkg::ID_END) |=>
		(play_start && play_id == $past(sq.fetch_id)))
		else $error("fetched identifier not played");

	chk_slot_advance: assert property (@(posedge clk) disable iff (!nrst)
		(state_q == wss_pkg::WSS_PLAY && go && play_done &&
		idx_q != wss_pkg::LAST_SLOT) |=>
		(idx_q == $past(idx_q) + wss_pkg::IDX_STEP &&
		state_q == wss_pkg::WSS_FETCH))
		else $error("walk did not advance to next slot");

	chk_zero_ends: assert property (@(posedge clk) disable iff (!nrst)
		(state_q == wss_pkg::WSS_FETCH && go &&
		sq.fetch_id == wss_pkg::ID_END) |=>
		(!play_start && seq_done) ##1 (!play_start && !seq_done))
		else $error("zero identifier did not end the walk");

	chk_eight_max: assert property (@(posedge clk) disable iff (!nrst)
		(state_q == wss_pkg::WSS_PLAY && go && play_done &&
		idx_q == wss_pkg::LAST_SLOT) |=>
		(state_q == wss_pkg::WSS_DONE && seq_done))
		else $error("walk ran past the eighth slot");

	chk_no_wrap: assert property (@(posedge clk) disable iff (!nrst)
		(state_q == wss_pkg::WSS_DONE && go) |=>
		(state_q == wss_pkg::WSS_DONE && !play_start && !seq_done))
		else $error("walk wrapped after completion");

	cov_zero_stop: cover property (@(posedge clk) disable iff (!nrst)
		state_q == wss_pkg::WSS_FETCH && go && sq.fetch_id == wss_pkg::ID_END);
	cov_all_eight: cover property (@(posedge clk) disable iff (!nrst)
		state_q == wss_pkg::WSS_PLAY && go && play_done &&
		idx_q == wss_pkg::LAST_SLOT);
	cov_cancel: cover property (@(posedge clk) disable iff (!nrst)
		state_q == wss_pkg::WSS_PLAY && !go);

endmodule : wss_engine
`default_nettype wire

/* design/wss_slots.sv */
`timescale 1ns/1ps
`default_nettype none
module wss_slots (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port, decoded from the serial interface
	input wire logic [wss_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [wss_pkg::ID_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [wss_pkg::ID_W-1:0] reg_rdata,
	output logic reg_hit,
	// Slots five to seven, held by the neighbouring bank
	input wire logic [wss_pkg::NUM_UPPER*wss_pkg::ID_W-1:0] upper_ids,
	// Trigger bit and its completion report
	input wire logic go,
	output logic seq_done,
	// Synthesizer handshake
	output logic play_start,
	output logic [wss_pkg::ID_W-1:0] play_id,
	input wire logic play_done,
	// Walker status
	output logic seq_busy,
	output logic [wss_pkg::IDX_W-1:0] cur_slot
);

	//////////////////////////////////////////////////////////////////////
	// Storage
	// Holds sequence_slot_zero_id through sequence_slot_four_id
	// Map of the local bank, lowest offset first:
	//   sequence_slot_zero_id   walk index zero, first offset
	//   sequence_slot_one_id    walk index one
	//   sequence_slot_two_id    walk index two
	//   sequence_slot_three_id  walk index three
	//   sequence_slot_four_id   walk index four, last local offset
	// Walk indices five to seven live in the neighbouring bank.
	logic [wss_pkg::ID_W-1:0] slots_q [wss_pkg::NUM_LOCAL];
	logic [wss_pkg::ID_W-1:0] slots_d [wss_pkg::NUM_LOCAL];
	logic [wss_pkg::ID_W-1:0] rdata_q, rdata_d; // Read answer
	logic wr_hit; // Write lands on a local slot
	logic rd_hit; // Read lands on a local slot
	logic [wss_pkg::IDX_W-1:0] acc_idx; // Local slot addressed
	logic [wss_pkg::NUM_LOCAL*wss_pkg::ID_W-1:0] slots_flat; // Bank, packed
	logic [wss_pkg::NUM_LOCAL*wss_pkg::ID_W-1:0] wr_mask; // Write target

	// Fetch path to the walker
	wss_seq_if sq ();

	//////////////////////////////////////////////////////////////////////
	// Address decode, shared by reads and writes
	// The index means something only on a hit; both strobes gate it
	assign acc_idx = wss_pkg::slot_index(reg_addr);
	assign wr_hit = reg_wr && wss_pkg::slot_hit(reg_addr);
	assign rd_hit = reg_rd && wss_pkg::slot_hit(reg_addr);
	// Combinational so the port logic can flag unmapped addresses early
	assign reg_hit = wss_pkg::slot_hit(reg_addr);

	//////////////////////////////////////////////////////////////////////
	// Slot next values
	// Writes are taken even while a walk runs; the walker simply picks
	// up the new identifier if it has not yet reached that slot.
	always_comb begin
		// Default: every slot keeps its identifier
		for (int i = 0; i < wss_pkg::NUM_LOCAL; i++) begin
			slots_d[i] = slots_q[i];
		end
		// A hit overwrites just the addressed slot
		if (wr_hit) begin
			slots_d[acc_idx] = reg_wdata;
		end
	end

	// Read answer next value
	// Unmapped reads answer zero; the answer holds between reads
	always_comb begin
		rdata_d = rdata_q;
		if (rd_hit) begin
			// Hit: stored identifier, before any write this cycle
			rdata_d = slots_q[acc_idx];
		end else if (reg_rd) begin
			// Miss: unmapped offsets answer the fixed value
			rdata_d = wss_pkg::RDATA_NONE;
		end
	end

	// Slot and answer registers
	// Synchronous reset clears every slot and the answer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < wss_pkg::NUM_LOCAL; i++) begin
				slots_q[i] <= wss_pkg::SLOT_RESET;
			end
			rdata_q <= wss_pkg::RDATA_NONE;
		end else begin
			for (int i = 0; i < wss_pkg::NUM_LOCAL; i++) begin
				slots_q[i] <= slots_d[i];
			end
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	//////////////////////////////////////////////////////////////////////
	// Packed view of the bank and the byte a write aims at
	// Used only by the checks; a packed vector lets them compare the
	// whole bank across cycles in one expression
	always_comb begin
		slots_flat = '0;
		wr_mask = '0;
		for (int i = 0; i < wss_pkg::NUM_LOCAL; i++) begin
			slots_flat[i*wss_pkg::ID_W +: wss_pkg::ID_W] = slots_q[i];
			// Byte lane of the addressed slot
			if (int'(acc_idx) == i) begin
				wr_mask[i*wss_pkg::ID_W +: wss_pkg::ID_W] = '1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Fetch mux: local slots first, remote ones above
	// Remote slots are read live; their bank keeps them stable
	always_comb begin
		logic [wss_pkg::IDX_W-1:0] up;
		up = sq.fetch_idx - wss_pkg::FIRST_UPPER;
		if (sq.fetch_idx < wss_pkg::FIRST_UPPER) begin
			// Local slot, straight from the bank
			sq.fetch_id = slots_q[sq.fetch_idx];
		end else begin
			// Remote slot, one byte lane of upper_ids
			sq.fetch_id = upper_ids[up*wss_pkg::ID_W +: wss_pkg::ID_W];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Walker
	// The walker owns the slot index; this bank only answers fetches.
	// A cleared trigger cancels the walk without a completion pulse.
	wss_engine u_engine (
		.clk(clk),
		.nrst(nrst),
		.go(go),
		.play_done(play_done),
		.play_start(play_start),
		.play_id(play_id),
		.seq_done(seq_done),
		.seq_busy(seq_busy),
		.sq(sq.engine)
	);

	assign cur_slot = sq.fetch_idx;

	//////////////////////////////////////////////////////////////////////
	// Checks
	// Port and storage behaviour; the walk itself is watched in the
	// walker, next to its state machine
	chk_slot_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_hit |=> (slots_q[$past(acc_idx)] == $past(reg_wdata)))
		else $error("slot write not stored");

	// A read in the cycle of a write answers the old identifier
	chk_slot_read: assert property (@(posedge clk) disable iff (!nrst)
		rd_hit |=>
		(reg_rdata == $past(slots_q[acc_idx])))
		else $error("slot read answer wrong");

	chk_unmapped_read: assert property (@(posedge clk)
		disable iff (!nrst)
		(reg_rd && !reg_hit) |=> (reg_rdata == wss_pkg::RDATA_NONE))
		else $error("unmapped read not zero");

	chk_fetch_local: assert property (@(posedge clk) disable iff (!nrst)
		(seq_busy && sq.fetch_idx < wss_pkg::FIRST_UPPER) |->
		(sq.fetch_id == slots_q[sq.fetch_idx]))
		else $error("walker fetched wrong local slot");

	// Only the five local offsets claim the port
	chk_hit_decode: assert property (@(posedge clk) disable iff (!nrst)
		reg_hit == ((reg_addr >= wss_pkg::WAVE_SLOT_0_OFF) &&
		(reg_addr <= wss_pkg::WAVE_SLOT_4_OFF)))
		else $error("slot decode claims wrong address");

	// A write that misses the bank leaves every slot alone
	chk_stray_write: assert property (@(posedge clk) disable iff (!nrst)
		(reg_wr && !reg_hit) |=> $stable(slots_flat))
		else $error("unmapped write changed a slot");

	// A write changes its own slot and no other
	chk_write_one: assert property (@(posedge clk) disable iff (!nrst)
		wr_hit |=> (((slots_flat ^ $past(slots_flat)) &
		~$past(wr_mask)) == '0))
		else $error("write spilled into another slot");

	// The answer stands until the next read strobe
	chk_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read answer changed without a read");

	// Leaving reset, the bank and the answer hold their reset values;
	// no disable here, since reset itself is what is being watched
	chk_reset_clear: assert property (@(posedge clk)
		!$past(nrst) |->
		(slots_flat == {wss_pkg::NUM_LOCAL{wss_pkg::SLOT_RESET}} &&
		reg_rdata == wss_pkg::RDATA_NONE))
		else $error("slot not cleared by reset");

	cov_write_then_go: cover property (@(posedge clk) disable iff (!nrst)
		wr_hit ##[1:4] (go && !seq_busy));

	cov_stray_write: cover property (@(posedge clk) disable iff (!nrst)
		reg_wr && !reg_hit);

endmodule : wss_slots
`default_nettype wire

/* tb/wss_synth_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Synthesizer stand-in: answers each waveform start with a done pulse
module wss_synth_model (
	// Clock
	input wire logic clk,
	// Start request and chosen play length
	input wire logic play_start,
	input wire logic [3:0] dly,
	// Finish pulse back to the walker
	output logic play_done
);
	////////////////////////////////////////////////////////////////////////
	// Waits dly extra cycles, so both prompt and slow finishes occur
	initial begin
		play_done = 1'b0;
		forever begin
			@(posedge clk);
			// Start seen: play for a while, then pulse one cycle
			if (play_start === 1'b1) begin
				repeat (dly) @(posedge clk);
				#1 play_done = 1'b1;
				@(posedge clk);
				#1 play_done = 1'b0;
			end
		end
	end
endmodule : wss_synth_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Bench for the slot bank: register port and the slot walk
module tb_top;
	logic clk, nrst, reg_wr, reg_rd, go, reg_hit; // Control
	logic play_start, play_done, seq_done, seq_busy; // Walker handshake
	logic [7:0] reg_addr, reg_wdata, reg_rdata, play_id; // Data
	logic [23:0] upper_ids; // Slots five to seven
	logic [2:0] cur_slot; // Walker position
	logic [3:0] dly; // Partner play length
	logic [31:0] rng; // Random state
	int err_total, compares; // Counters
	int ref_slot [8]; // Reference copy of all eight slots
	int zp [4] = '{2, 0, 5, 8}; // Zero slot per walk, 8 meaning none

	wss_slots DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit), .upper_ids(upper_ids),
		.go(go), .seq_done(seq_done), .play_start(play_start),
		.play_id(play_id), .play_done(play_done), .seq_busy(seq_busy),
		.cur_slot(cur_slot));
	wss_synth_model u_synth (.clk(clk), .play_start(play_start),
		.dly(dly), .play_done(play_done));

	////////////////////////////////////////////////////////////////////////
	// Xorshift step for stimulus values
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction : xs

	// Compare and count; case inequality so unknowns fail
	task automatic check(input logic [7:0] act, input logic [7:0] exp);
		compares++;
		if (act !== exp) begin
			err_total++;
			$display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
		end
	endtask : check

	// One write strobe; the model keeps only mapped slots
	task automatic wr_reg(input logic [7:0] a, input int d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = 8'(d);
		reg_wr = 1'b1;
		if (a >= 8'h03 && a <= 8'h07) begin
			ref_slot[a - 8'h03] = d;
		end
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask : wr_reg

	// One read strobe; answer is looked at one cycle later
	task automatic rd_chk(input logic [7:0] a);
		logic [7:0] exp;
		logic hit;
		hit = (a >= 8'h03 && a <= 8'h07);
		exp = hit ? 8'(ref_slot[a - 8'h03]) : 8'h00;
		@(posedge clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check(reg_rdata, exp);
		check(8'(reg_hit), 8'(hit));
	endtask : rd_chk

	// Trigger, follow the walk, then hold go to prove no restart
	task automatic run_seq();
		int n, k, t;
		int exp_q [$];
		n = 0;
		k = 0;
		// Expected plays: slots in order up to the first zero, eight at most
		while (n < 8 && ref_slot[n] != 0) begin
			exp_q.push_back(ref_slot[n]);
			n++;
		end
		@(posedge clk);
		#1 upper_ids = {8'(ref_slot[7]), 8'(ref_slot[6]), 8'(ref_slot[5])};
		go = 1'b1;
		for (t = 0; t < 600 && seq_done !== 1'b1; t++) begin
			@(posedge clk);
			#1;
			if (play_start === 1'b1) begin
				if (exp_q.size() > 0) begin
					check(play_id, 8'(exp_q.pop_front()));
				end else begin
					check(8'(play_start), 8'h00);
				end
				check(8'(cur_slot), 8'(k));
				check(8'(seq_busy), 8'h01);
				k++;
			end
		end
		check(8'(seq_done), 8'h01);
		check(8'(k), 8'(n));
		check(8'(exp_q.size()), 8'h00);
		// Walker must sit still after the eighth or the zero slot
		repeat (3) begin
			@(posedge clk);
			#1 check({6'h00, play_start, seq_busy}, 8'h00);
		end
		go = 1'b0;
		repeat (2) @(posedge clk);
	endtask : run_seq

	// Counts, verdict and end of run
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Watchdog, far beyond the few hundred cycles expected
	initial begin
		#500000;
		err_total++;
		complete_run();
	end

	// Main sequence
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		go = 1'b0;
		upper_ids = 24'h000000;
		dly = 4'h0;
		rng = 32'h048e;
		foreach (ref_slot[i]) ref_slot[i] = 0;
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		// Reset values, with unmapped neighbours reading zero
		for (int a = 2; a < 9; a++) rd_chk(8'(a));
		// Walks ending at slot 2, slot 0, the bank edge, and all eight
		for (int r = 0; r < 4; r++) begin
			for (int s = 0; s < 8; s++) begin
				rng = xs(rng);
				if (s < 5) begin
					wr_reg(8'(s + 3), (s == zp[r]) ? 0 : (rng[7:0] | 8'h01));
				end else begin
					ref_slot[s] = (s == zp[r]) ? 0 : (rng[7:0] | 8'h01);
				end
			end
			// Unmapped writes must leave every slot alone
			wr_reg(8'h02, 8'hFF);
			wr_reg(8'h08, 8'hFF);
			for (int a = 2; a < 9; a++) rd_chk(8'(a));
			dly = 4'(r * 5);
			run_seq();
		end
		// Cancel mid-walk: the walker idles with no completion pulse
		@(posedge clk);
		#1 go = 1'b1;
		repeat (3) @(posedge clk);
		#1 check({6'h00, play_start, seq_busy}, 8'h01);
		go = 1'b0;
		@(posedge clk);
		#1 check({6'h00, seq_busy, seq_done}, 8'h00);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
